// *** rtl/gpibrl_pkg.sv ***
// constants for the bus remote/local interface control block
package gpibrl_pkg;
   // multiline commands seen while attention is asserted
   localparam logic [7:0] CMD_GTL = 8'h01;
   localparam logic [7:0] CMD_SDC = 8'h04;
   localparam logic [7:0] CMD_PPC = 8'h05;
   localparam logic [7:0] CMD_GET = 8'h08;
   localparam logic [7:0] CMD_TCT = 8'h09;
   localparam logic [7:0] CMD_LLO = 8'h11;
   localparam logic [7:0] CMD_DCL = 8'h14;
   localparam logic [7:0] CMD_PPU = 8'h15;
   localparam logic [7:0] CMD_SPE = 8'h18;
   localparam logic [7:0] CMD_SPD = 8'h19;
   localparam logic [7:0] CMD_UNL = 8'h3F;
   localparam logic [7:0] CMD_UNT = 8'h5F;
   localparam logic [2:0] ADDR_GROUP_LISTEN = 3'h1;
   localparam logic [2:0] ADDR_GROUP_TALK   = 3'h2;
   // status byte layout
   localparam int STB_RQS_BIT   = 7;
   localparam int STB_ERR_BIT   = 2;
   localparam int STB_READY_BIT = 1;
   localparam int STB_CODE_BIT  = 0;
   // settings forced by a device clear
   localparam logic [1:0] MEAS_AC_LEVEL     = 2'h0;
   localparam logic [1:0] TRIG_FREE_RUN     = 2'h0;
   localparam logic [1:0] LPF_80KHZ         = 2'h2;
   localparam logic [7:0] SRQ_COND_DEFAULT  = 8'h22;
   localparam logic [7:0] STB_RESET         = 8'h00;
   // data-path buffer
   localparam int BUF_DEPTH = 2;
   localparam int BUF_WIDTH = 8;
endpackage

// *** rtl/gpibrl_remote_local.sv ***
// remote/local, addressing, command decode and service request logic
`timescale 1ns/1ps
// Function
// RULE1 - remote disables keys except local, clear
// RULE2 - remote listener takes data, trigger, SDC, GTL
// RULE3 - talker sources data or status byte
// RULE4 - DCL, LLO, REN, IFC regardless of addressing
// RULE5 - REN plus own listen address enters remote
// RULE6 - entering remote lights remote, addressed lamps
// RULE7 - local keeps keys, answers universal messages
// RULE8 - local still talks and requests service
// RULE9 - GTL while listener or REN false: local
// RULE10 - local key works only without lockout
// RULE11 - commands decoded only with ATN, not IFC
// RULE12 - addressed lamp whenever talker or listener
// RULE13 - bus address comes from switches
// RULE14 - GET or settled code triggers one measurement
// RULE15 - clear sets defaults, clears status, lockout
// RULE16 - enter remote keeps settings, drops entries
// RULE17 - return local keeps settings, forces free run
// RULE18 - lockout disables every key including local
// RULE19 - REN false clears lockout, goes local
// RULE20 - never a controller, ignore pass control
// RULE21 - service on bad code, ready, error
// RULE22 - RQS and cause latched until read
// RULE23 - IFC drops talker and listener at once
// RULE24 - no parallel poll response
// RULE25 - synchronise REN, ATN, IFC before use
module gpibrl_remote_local (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       busRen,
   input  wire logic       busAtn,
   input  wire logic       busIfc,
   input  wire logic [7:0] busData,
   input  wire logic       busByteValid,
   input  wire logic [4:0] addressSwitch,
   input  wire logic       localReturnKey,
   input  wire logic       shiftedClearKey,
   input  wire logic       panelKey,
   input  wire logic       badCodeEvent,
   input  wire logic       settledTriggerCode,
   input  wire logic       readyEvent,
   input  wire logic       errorEvent,
   input  wire logic       readySrqEnable,
   input  wire logic       errorSrqEnable,
   input  wire logic [7:0] talkData,
   input  wire logic       talkValid,
   output logic            talkReady,
   input  wire logic       busTakeReady,
   output logic [7:0]      busOutData,
   output logic            busOutValid,
   output logic [7:0]      listenData,
   output logic            listenValid,
   input  wire logic       listenReady,
   output logic            busSrq,
   output logic            remoteLamp,
   output logic            addressedLamp,
   output logic            lockout,
   output logic            panelKeyAccepted,
   output logic            clearKeyAccepted,
   output logic            discardEntries,
   output logic            measureTrigger,
   output logic            deviceClear,
   output logic [1:0]      measureMode,
   output logic [1:0]      lowpassFilterSelect,
   output logic [1:0]      triggerMode,
   output logic [7:0]      srqCondition
);
   typedef enum logic {GPIBRL_LOCAL, GPIBRL_REMOTE} gpibrl_mode_t;
   gpibrl_mode_t mode;
   logic renMeta, renSync, atnMeta, atnSync, ifcMeta, ifcSync; // RULE25
   logic listener, talker, serialPoll;
   logic [7:0] statusByte;
   logic [7:0] bufData [gpibrl_pkg::BUF_DEPTH];
   logic       bufWr, bufRd;
   logic [1:0] bufCount;
   // decode
   wire cmdMode    = atnSync && !ifcSync; // RULE11
   wire cmdByte    = busByteValid && cmdMode;
   wire dataByte   = busByteValid && !atnSync && !ifcSync;
   wire [7:0] cmd  = {1'b0, busData[6:0]};
   wire myListen   = cmdByte && busData[7:5] == gpibrl_pkg::ADDR_GROUP_LISTEN
                     && busData[4:0] == addressSwitch; // RULE13
   wire myTalk     = cmdByte && busData[7:5] == gpibrl_pkg::ADDR_GROUP_TALK
                     && busData[4:0] == addressSwitch;
   wire isUnl      = cmdByte && cmd == gpibrl_pkg::CMD_UNL;
   wire isUnt      = cmdByte && cmd == gpibrl_pkg::CMD_UNT;
   wire otherTalk  = cmdByte && busData[7:5] == gpibrl_pkg::ADDR_GROUP_TALK && !myTalk;
   wire isDcl      = cmdByte && cmd == gpibrl_pkg::CMD_DCL; // RULE4
   wire isSdc      = cmdByte && cmd == gpibrl_pkg::CMD_SDC && listener; // RULE2
   wire isGtl      = cmdByte && cmd == gpibrl_pkg::CMD_GTL && listener; // RULE9
   wire isGet      = cmdByte && cmd == gpibrl_pkg::CMD_GET && listener;
   wire isLlo      = cmdByte && cmd == gpibrl_pkg::CMD_LLO; // RULE4
   wire isSpe      = cmdByte && cmd == gpibrl_pkg::CMD_SPE;
   wire isSpd      = cmdByte && cmd == gpibrl_pkg::CMD_SPD;
   // pass control, parallel poll configure/unconfigure fall through unused RULE20 RULE24
   wire doClear    = isDcl || isSdc; // RULE15
   wire enterRem   = renSync && mode == GPIBRL_LOCAL && myListen; // RULE5
   wire keyLocal   = mode == GPIBRL_REMOTE && localReturnKey && !lockout; // RULE10
   wire goLocal    = mode == GPIBRL_REMOTE && (isGtl || !renSync || keyLocal); // RULE9
   wire remoteNow  = mode == GPIBRL_REMOTE;
   wire keyOk      = !lockout && !remoteNow; // RULE1 RULE7 RULE18
   wire clrKeyOk   = !lockout; // RULE1 RULE18
   wire trigNow    = remoteNow && (isGet || (settledTriggerCode && listener)); // RULE14
   wire srqCause   = statusByte[gpibrl_pkg::STB_CODE_BIT]
                     || statusByte[gpibrl_pkg::STB_READY_BIT]
                     || statusByte[gpibrl_pkg::STB_ERR_BIT];
   wire pollRead   = serialPoll && talker && busTakeReady && busOutValid;
   // two-entry listen buffer; a data byte arriving while it is full is dropped
   wire listenIn   = dataByte && listener && renSync; // RULE2
   wire bufFull    = bufCount == 2'(gpibrl_pkg::BUF_DEPTH);
   assign bufWr    = listenIn && !bufFull;
   assign bufRd    = listenValid && listenReady;
   wire [1:0] next_bufCount = bufCount + {1'b0, bufWr} - {1'b0, bufRd};
   // ready only while the output holds nothing, so a stalled word is never overwritten by talkData
   wire takeTalk            = talkValid && talkReady;
   wire next_busOutValid    = talker && (serialPoll || takeTalk || (busOutValid && !busTakeReady));
   wire next_talkReady      = talker && !serialPoll && !next_busOutValid;

   always_ff @(posedge core_clk) begin
      renMeta <= busRen;
      renSync <= renMeta;
      atnMeta <= busAtn;
      atnSync <= atnMeta;
      ifcMeta <= busIfc;
      ifcSync <= ifcMeta;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode <= GPIBRL_LOCAL;
         lockout <= 1'b0;
         listener <= 1'b0;
         talker <= 1'b0;
         serialPoll <= 1'b0;
      end else begin
         if (enterRem) begin
            mode <= GPIBRL_REMOTE; // RULE5 RULE16
         end else if (goLocal) begin
            mode <= GPIBRL_LOCAL; // RULE9 RULE17
         end
         if (!renSync || doClear) begin
            lockout <= 1'b0; // RULE19 RULE15
         end else if (isLlo) begin
            lockout <= 1'b1; // RULE18
         end
         if (ifcSync) begin
            listener <= 1'b0; // RULE23
            talker <= 1'b0;
         end else begin
            if (myListen) begin
               listener <= 1'b1;
            end else if (isUnl || myTalk) begin
               listener <= 1'b0;
            end
            if (myTalk) begin
               talker <= 1'b1; // RULE3 RULE8
            end else if (isUnt || otherTalk || myListen) begin
               talker <= 1'b0;
            end
         end
         if (isSpe) begin
            serialPoll <= 1'b1;
         end else if (isSpd || ifcSync) begin
            serialPoll <= 1'b0;
         end
      end
   end

   // status bits: an event wins over a read in the same cycle
   always_ff @(posedge core_clk) begin
      if (!reset_n || doClear) begin
         statusByte <= gpibrl_pkg::STB_RESET; // RULE15
      end else begin
         statusByte[gpibrl_pkg::STB_CODE_BIT] <= badCodeEvent
            || (statusByte[gpibrl_pkg::STB_CODE_BIT] && !pollRead); // RULE21 RULE22
         statusByte[gpibrl_pkg::STB_READY_BIT] <= (readyEvent && readySrqEnable)
            || (statusByte[gpibrl_pkg::STB_READY_BIT] && !pollRead);
         statusByte[gpibrl_pkg::STB_ERR_BIT] <= (errorEvent && errorSrqEnable)
            || (statusByte[gpibrl_pkg::STB_ERR_BIT] && !pollRead);
         statusByte[gpibrl_pkg::STB_RQS_BIT] <= srqCause; // RULE22
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bufCount <= 2'h0;
         listenValid <= 1'b0;
         listenData <= 8'h00;
         bufData[0] <= 8'h00;
         bufData[1] <= 8'h00;
      end else begin
         bufCount <= next_bufCount;
         if (bufWr) begin
            bufData[(bufCount == 2'h0 || (bufCount == 2'h1 && bufRd)) ? 0 : 1] <= busData;
         end
         if (bufRd) begin
            bufData[0] <= (bufWr && bufCount == 2'h1) ? busData : bufData[1];
         end
         listenValid <= next_bufCount != 2'h0;
         listenData <= (bufCount == 2'h0 || (bufCount == 2'h1 && bufRd)) && bufWr ? busData
                      : bufRd ? bufData[1] : bufData[0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         busOutData <= 8'h00;
         busOutValid <= 1'b0;
         talkReady <= 1'b0;
      end else begin
         talkReady <= next_talkReady;
         if (!talker) begin
            busOutValid <= 1'b0; // RULE23
         end else if (serialPoll) begin
            busOutData <= statusByte; // RULE3 RULE22
            busOutValid <= 1'b1;
         end else if (talkValid && talkReady) begin
            busOutData <= talkData; // RULE3
            busOutValid <= 1'b1;
         end else if (busTakeReady) begin
            busOutValid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         busSrq <= 1'b0;
         remoteLamp <= 1'b0;
         addressedLamp <= 1'b0;
         panelKeyAccepted <= 1'b0;
         clearKeyAccepted <= 1'b0;
         discardEntries <= 1'b0;
         measureTrigger <= 1'b0;
         deviceClear <= 1'b0;
         measureMode <= gpibrl_pkg::MEAS_AC_LEVEL;
         lowpassFilterSelect <= gpibrl_pkg::LPF_80KHZ;
         triggerMode <= gpibrl_pkg::TRIG_FREE_RUN;
         srqCondition <= gpibrl_pkg::SRQ_COND_DEFAULT;
      end else begin
         busSrq <= srqCause && !doClear; // RULE4 RULE21
         remoteLamp <= (remoteNow && !goLocal) || enterRem; // RULE6
         addressedLamp <= (listener || talker || enterRem) && !ifcSync; // RULE6 RULE12
         panelKeyAccepted <= panelKey && keyOk; // RULE1 RULE7
         clearKeyAccepted <= shiftedClearKey && clrKeyOk; // RULE1
         discardEntries <= enterRem || goLocal; // RULE16 RULE17 RULE19
         measureTrigger <= trigNow; // RULE14
         deviceClear <= doClear;
         if (doClear || goLocal) begin
            triggerMode <= gpibrl_pkg::TRIG_FREE_RUN; // RULE15 RULE17 RULE19
         end
         if (doClear) begin
            measureMode <= gpibrl_pkg::MEAS_AC_LEVEL; // RULE15
            lowpassFilterSelect <= gpibrl_pkg::LPF_80KHZ;
            srqCondition <= gpibrl_pkg::SRQ_COND_DEFAULT;
         end
      end
   end
endmodule

// *** verif/gpibrl_rl_sva.sv ***
// port assertions for the remote/local control block
`timescale 1ns/1ps
module gpibrl_rl_sva (
   input wire logic       core_clk,
   input wire logic       reset_n,
   input wire logic       busRen,
   input wire logic       busIfc,
   input wire logic       badCodeEvent,
   input wire logic       localReturnKey,
   input wire logic       shiftedClearKey,
   input wire logic       panelKey,
   input wire logic       busSrq,
   input wire logic       remoteLamp,
   input wire logic       addressedLamp,
   input wire logic       lockout,
   input wire logic       panelKeyAccepted,
   input wire logic       clearKeyAccepted,
   input wire logic       deviceClear,
   input wire logic [1:0] measureMode,
   input wire logic [1:0] lowpassFilterSelect,
   input wire logic [1:0] triggerMode,
   input wire logic [7:0] srqCondition
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   AST_ENTER_LAMPS: assert property ($rose(remoteLamp) |-> addressedLamp)
      else $error("remote lamp lit without addressed lamp");
   AST_REN_DROP: assert property ($fell(busRen) |-> ##[1:6] (!remoteLamp && !lockout))
      else $error("remote or lockout kept after enable dropped");
   AST_NO_REN: assert property ((!busRen) [*7] |-> !remoteLamp)
      else $error("remote without enable");
   AST_BAD_SRQ: assert property (badCodeEvent |-> ##[1:3] busSrq)
      else $error("no service request on bad code");
   AST_CLEAR: assert property (deviceClear |-> ##[0:2] (
      measureMode == gpibrl_pkg::MEAS_AC_LEVEL && triggerMode == gpibrl_pkg::TRIG_FREE_RUN &&
      lowpassFilterSelect == gpibrl_pkg::LPF_80KHZ &&
      srqCondition == gpibrl_pkg::SRQ_COND_DEFAULT && !lockout && !busSrq))
      else $error("clear left wrong settings");
   AST_LOCK_KEYS: assert property (lockout && (localReturnKey || shiftedClearKey || panelKey)
      |=> (!(panelKeyAccepted || clearKeyAccepted)) [*2]) else $error("key taken under lockout");
   AST_CLR_KEY: assert property (!lockout && shiftedClearKey |-> ##[1:2] clearKeyAccepted)
      else $error("clear key refused");
   AST_IFC: assert property ($rose(busIfc) |-> ##[1:6] !addressedLamp)
      else $error("still addressed after interface clear");
endmodule

// *** verif/gpibrl_ctl.sv ***
// bus controller model: control lines, command and data bytes, talker intake
`timescale 1ns/1ps
module gpibrl_ctl (
   input  wire logic       core_clk,
   output logic            busRen,
   output logic            busAtn,
   output logic            busIfc,
   output logic [7:0]      busData,
   output logic            busByteValid,
   output logic            busTakeReady,
   input  wire logic [7:0] busOutData,
   input  wire logic       busOutValid
);
   logic [7:0] outQ[$];
   logic       stall = 1'b0;
   initial {busRen, busAtn, busIfc, busData, busByteValid, busTakeReady} = '0;
   // lines settle past the synchroniser before any byte relies on them
   task lines(input logic r, input logic f);
      @(negedge core_clk);
      busRen = r;
      busIfc = f;
      repeat (3) @(negedge core_clk);
   endtask
   task atn(input logic a);
      @(negedge core_clk);
      busAtn = a;
      repeat (3) @(negedge core_clk);
   endtask
   task send(input logic a, input logic [7:0] b);
      atn(a);
      busData = b;
      busByteValid = 1'b1;
      @(negedge core_clk);
      busByteValid = 1'b0;
      busData = ~b; // released lines show no stale byte
   endtask
   always @(negedge core_clk) busTakeReady <= stall ? ~busTakeReady : 1'b1;
   always @(posedge core_clk) if (busOutValid && busTakeReady) outQ.push_back(busOutData);
endmodule

// *** verif/gpib_remote_local_control_test.sv ***
// self-checking bench for the remote/local control block
`timescale 1ns/1ps
module gpib_remote_local_control_test;
   logic       core_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [6:0] ev = 7'h00;
   logic [1:0] en = 2'h0;
   logic [4:0] addressSwitch = 5'h00;
   logic [7:0] talkData = 8'h00;
   logic [7:0] rnd = 8'h25;
   logic       talkValid = 1'b0;
   logic       listenReady = 1'b0;
   logic       busRen, busAtn, busIfc, busByteValid, busTakeReady, talkReady, busOutValid;
   logic [7:0] busData, busOutData, listenData, srqCondition;
   logic [1:0] measureMode, lowpassFilterSelect, triggerMode;
   logic       listenValid, busSrq, remoteLamp, addressedLamp, lockout, panelKeyAccepted;
   logic       clearKeyAccepted, discardEntries, measureTrigger, deviceClear;
   logic [7:0] q[$];
   int         err_total = 0;
   int         checked = 0;
   wire  [7:0] la = {gpibrl_pkg::ADDR_GROUP_LISTEN, addressSwitch};
   wire  [7:0] fl = {busSrq, remoteLamp, addressedLamp, lockout, deviceClear,
                     measureTrigger, clearKeyAccepted, panelKeyAccepted};
   always #5 core_clk = ~core_clk;
   gpibrl_remote_local u_gpibrl_remote_local (
      .core_clk, .reset_n, .busRen, .busAtn, .busIfc, .busData, .busByteValid, .addressSwitch,
      .localReturnKey(ev[0]), .shiftedClearKey(ev[1]), .panelKey(ev[2]), .badCodeEvent(ev[3]),
      .settledTriggerCode(ev[4]), .readyEvent(ev[5]), .errorEvent(ev[6]),
      .readySrqEnable(en[0]), .errorSrqEnable(en[1]), .talkData, .talkValid, .talkReady,
      .busTakeReady, .busOutData, .busOutValid, .listenData, .listenValid, .listenReady,
      .busSrq, .remoteLamp, .addressedLamp, .lockout, .panelKeyAccepted, .clearKeyAccepted,
      .discardEntries, .measureTrigger, .deviceClear, .measureMode, .lowpassFilterSelect,
      .triggerMode, .srqCondition);
   gpibrl_ctl u_gpibrl_ctl (.core_clk, .busRen, .busAtn, .busIfc, .busData, .busByteValid,
      .busTakeReady, .busOutData, .busOutValid);
   function logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task end_of_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk1(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t flag %b expected %b", $time, g, e);
      end
   endtask
   task chk8(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t byte %h expected %h", $time, g, e);
      end
   endtask
   // bounded wait; a pulse already showing counts at once
   task waitf(input int i, input logic v);
      int k;
      k = 0;
      while (fl[i] !== v && k < 12) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk1(fl[i], v);
      if (fl[i] !== v) end_of_test();
   endtask
   task hold(input int i, input logic v);
      int k;
      k = 0;
      repeat (6) begin
         @(posedge core_clk);
         #1;
         if (fl[i] !== v) k++;
      end
      chk1(k == 0, 1'b1);
   endtask
   task pulse(input int i);
      @(negedge core_clk);
      ev[i] = 1'b1;
      @(negedge core_clk);
      ev[i] = 1'b0;
   endtask
   initial begin
      addressSwitch = 5'(rnd % 30);
      repeat (20) @(negedge core_clk);
      reset_n = 1'b1;
      chk8(srqCondition, gpibrl_pkg::SRQ_COND_DEFAULT);
      chk8({6'h00, lowpassFilterSelect}, {6'h00, gpibrl_pkg::LPF_80KHZ});
      u_gpibrl_ctl.lines(1'b1, 1'b0);
      u_gpibrl_ctl.send(1'b1, la ^ 8'h01);
      hold(6, 1'b0);
      u_gpibrl_ctl.send(1'b1, la);
      waitf(6, 1'b1);
      chk1(discardEntries, 1'b1);
      chk1(addressedLamp, 1'b1);
      pulse(2);
      hold(0, 1'b0);
      pulse(1);
      waitf(1, 1'b1);
      u_gpibrl_ctl.send(1'b1, gpibrl_pkg::CMD_GET);
      waitf(2, 1'b1);
      pulse(4);
      waitf(2, 1'b1);
      for (int k = 0; k < 3; k++) begin
         rnd = nxt(rnd);
         u_gpibrl_ctl.send(1'b0, rnd);
         if (q.size() < 2) q.push_back(rnd);
      end
      listenReady = 1'b1;
      for (int k = 0; k < 8; k++) begin
         if (listenValid === 1'b1 && q.size() > 0) chk8(listenData, q.pop_front());
         @(negedge core_clk);
      end
      chk1(q.size() == 0 && listenValid === 1'b0, 1'b1);
      pulse(3);
      waitf(7, 1'b1);
      u_gpibrl_ctl.stall = 1'b1;
      u_gpibrl_ctl.send(1'b1, {gpibrl_pkg::ADDR_GROUP_TALK, addressSwitch});
      u_gpibrl_ctl.send(1'b1, gpibrl_pkg::CMD_SPE);
      u_gpibrl_ctl.atn(1'b0);
      waitf(7, 1'b0);
      chk8(u_gpibrl_ctl.outQ[0], 8'(1 << gpibrl_pkg::STB_RQS_BIT) | 8'h01);
      u_gpibrl_ctl.send(1'b1, gpibrl_pkg::CMD_SPD);
      u_gpibrl_ctl.atn(1'b0);
      u_gpibrl_ctl.outQ.delete();
      rnd = nxt(rnd);
      talkData = rnd;
      talkValid = 1'b1;
      for (int k = 0; k < 20 && talkReady !== 1'b1; k++) @(negedge core_clk);
      chk1(talkReady, 1'b1);
      if (talkReady !== 1'b1) end_of_test();
      @(negedge core_clk);
      talkValid = 1'b0;
      repeat (8) @(negedge core_clk);
      chk8(u_gpibrl_ctl.outQ.size() > 0 ? u_gpibrl_ctl.outQ[0] : ~rnd, rnd);
      u_gpibrl_ctl.send(1'b1, gpibrl_pkg::CMD_LLO);
      waitf(4, 1'b1);
      pulse(0);
      pulse(1);
      hold(6, 1'b1);
      en = 2'h1;
      pulse(6);
      hold(7, 1'b0);
      en = 2'h2;
      pulse(6);
      waitf(7, 1'b1);
      u_gpibrl_ctl.send(1'b1, gpibrl_pkg::CMD_DCL);
      waitf(3, 1'b1);
      waitf(4, 1'b0);
      chk8({4'h0, measureMode, triggerMode}, {4'h0, gpibrl_pkg::MEAS_AC_LEVEL, gpibrl_pkg::TRIG_FREE_RUN});
      u_gpibrl_ctl.send(1'b1, la);
      u_gpibrl_ctl.send(1'b1, gpibrl_pkg::CMD_GTL);
      waitf(6, 1'b0);
      u_gpibrl_ctl.send(1'b1, la);
      waitf(6, 1'b1);
      u_gpibrl_ctl.send(1'b1, gpibrl_pkg::CMD_LLO);
      waitf(4, 1'b1);
      u_gpibrl_ctl.lines(1'b0, 1'b0);
      waitf(6, 1'b0);
      waitf(4, 1'b0);
      u_gpibrl_ctl.send(1'b1, la);
      waitf(5, 1'b1);
      u_gpibrl_ctl.lines(1'b1, 1'b1);
      waitf(5, 1'b0);
      end_of_test();
   end
endmodule
bind gpibrl_remote_local gpibrl_rl_sva u_gpibrl_rl_sva (.core_clk, .reset_n, .busRen, .busIfc,
   .badCodeEvent, .localReturnKey, .shiftedClearKey, .panelKey, .busSrq, .remoteLamp,
   .addressedLamp, .lockout, .panelKeyAccepted, .clearKeyAccepted, .deviceClear, .measureMode,
   .lowpassFilterSelect, .triggerMode, .srqCondition);
